// File: rtl/sdr_host.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module sdr_host
	import sdr_pkg::*;
(
	sdr_link_if.host    link,
	input  wire logic   clock,
	input  wire logic   rstn,
	input  wire logic   psel,
	input  wire logic   penable,
	input  wire logic   pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr
);
	import sdr_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_SHIFT = 3'h2,
		ST_LOAD  = 3'h4
	} sdr_state_type;

	sdr_state_type     st_r, st_nxt;
	logic [WORD_W-1:0] data_r, data_nxt, sh_r, sh_nxt;
	logic [4:0]        bit_r, bit_nxt;
	logic [1:0]        div_r, div_nxt;
	logic              sclk_r, sclk_nxt, sload_r, sload_nxt;
	logic              cal_r, cal_nxt;
	logic [31:0]       rd_nxt;
	logic              acc;

	function automatic logic is_div(input logic [2:0] s);
		return (s == SEL_INT) || (s == SEL_MOD) || (s == SEL_FRAC);
	endfunction

	assign acc = psel && penable;
	assign link.sclk  = sclk_r;
	assign link.sload = sload_r;
	assign link.sdata = sh_r[WORD_W-1]; // [R13]

	always_comb begin
		st_nxt    = st_r;
		data_nxt  = data_r;
		sh_nxt    = sh_r;
		bit_nxt   = bit_r;
		div_nxt   = div_r + 2'h1;
		sclk_nxt  = sclk_r;
		sload_nxt = sload_r;
		cal_nxt   = cal_r;
		rd_nxt    = 32'h0;
		if (acc && pwrite && paddr == A_DATA) begin
			// Software supplies select code and field [R1] [R5] [R8]; it must keep
			// upper bits zero [R4], ranges valid [R2] [R6] [R9], dividers last [R11]
			data_nxt = pwdata[WORD_W-1:0];
		end
		// Decoded in setup so the data stands at the edge that samples pready
		if (psel && !penable && !pwrite) begin
			case (paddr)
				A_DATA:  rd_nxt = {8'h0, data_r};
				A_STAT:  rd_nxt = {30'h0, cal_r, st_r != ST_IDLE};
				default: rd_nxt = 32'h0;
			endcase
		end
		case (st_r)
			ST_IDLE: begin
				sclk_nxt = 1'b0;
				div_nxt  = 2'h0;
				if (acc && pwrite && paddr == A_CTRL && pwdata[CTRL_GO]) begin
					st_nxt    = ST_SHIFT;
					sh_nxt    = data_r;
					bit_nxt   = 5'h0;
					sload_nxt = 1'b0;
					cal_nxt   = is_div(data_r[ADDR_W-1:0]); // [R10]
				end
			end
			ST_SHIFT: begin
				// Data changes on the falling edge, device samples on rising
				if (div_r == 2'h1) begin
					sclk_nxt = 1'b1;
				end else if (div_r == 2'h3) begin
					sclk_nxt = 1'b0;
					sh_nxt   = {sh_r[WORD_W-2:0], 1'b0};
					bit_nxt  = bit_r + 5'h1;
					if (bit_r == 5'(WORD_W - 1)) begin
						st_nxt = ST_LOAD;
					end
				end
			end
			ST_LOAD: begin
				// Strobe high with a few clocks so the device sees the edge [R14]
				sload_nxt = 1'b1;
				if (div_r == 2'h1) begin
					sclk_nxt = 1'b1;
				end else if (div_r == 2'h3) begin
					sclk_nxt = 1'b0;
					bit_nxt  = bit_r + 5'h1;
					if (bit_r == 5'(WORD_W + 2)) begin
						st_nxt = ST_IDLE;
					end
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_r    <= ST_IDLE;
			data_r  <= '0;
			sh_r    <= '0;
			bit_r   <= 5'h0;
			div_r   <= 2'h0;
			sclk_r  <= 1'b0;
			sload_r <= 1'b1;
			cal_r   <= 1'b0;
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			data_r  <= data_nxt;
			sh_r    <= sh_nxt;
			bit_r   <= bit_nxt;
			div_r   <= div_nxt;
			sclk_r  <= sclk_nxt;
			sload_r <= sload_nxt;
			cal_r   <= cal_nxt;
			prdata  <= rd_nxt;
			pready  <= psel && !penable;
			pslverr <= 1'b0;
		end
	end
endmodule // sdr_host
`default_nettype wire

// File: rtl/sdr_pkg.sv
package sdr_pkg;
	localparam int WORD_W = 24;
	localparam int ADDR_W = 3;
	localparam int FIELD_W = 11;
	localparam int FIELD_LSB = 3;
	localparam int FIELD_MSB = 13;
	localparam int DITHER_W = 17;
	localparam int DITHER_LSB = 3;
	localparam int INT_W = 7;
	localparam logic [2:0] SEL_INT = 3'h0;
	localparam logic [2:0] SEL_MOD = 3'h1;
	localparam logic [2:0] SEL_FRAC = 3'h2;
	localparam logic [2:0] SEL_DITHER = 3'h3;
	localparam logic [10:0] MOD_RESET = 11'h600;
	localparam logic [10:0] FRAC_RESET = 11'h300;
	localparam logic [16:0] DITHER_RESET = 17'h00001;
	localparam logic [6:0] INT_RESET = 7'h18;
	localparam int CLK_DIV = 4;
	// Host APB register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_DATA = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam int CTRL_GO = 0;
	localparam int STAT_BUSY = 0;
	localparam int STAT_CAL = 1;
endpackage

// File: rtl/sdr_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sdr_link_if;
	logic sclk;
	logic sdata;
	logic sload;
	modport host (output sclk, output sdata, output sload);
	modport device (input sclk, input sdata, input sload);
endinterface
`default_nettype wire

// File: rtl/sdr_device.sv
// Summary of operation
// [R1] Select code 001 loads modulus register
// [R2] Host keeps modulus within 1 to 2047
// [R3] Modulus in bits 13..3, reset 1536
// [R4] Host sends upper bits 23..14 zero
// [R5] Select code 010 loads fractional register
// [R6] Host keeps fraction below modulus
// [R7] Fraction in bits 13..3, reset 768
// [R8] Select code 011 loads dither register
// [R9] Dither restart value is 17 bits
// [R10] Divider write starts PLL calibration
// [R11] Host writes divider registers last
// [R12] VCO = PHASE_FREQ_DETECTOR x (INT + FRAC/MOD) x 2
// [R13] Registers loaded over three-wire serial port
// [R14] Commit word only on load strobe
// [R15] Upper bits ignored in field decode
`timescale 1ns/10ps
`default_nettype none
module sdr_device
	import sdr_pkg::*;
(
	sdr_link_if.device                link,
	input  wire logic                 clock,
	input  wire logic                 rstn,
	output logic [sdr_pkg::INT_W-1:0]    int_value,
	output logic [sdr_pkg::FIELD_W-1:0]  mod_value,
	output logic [sdr_pkg::FIELD_W-1:0]  frac_value,
	output logic [sdr_pkg::DITHER_W-1:0] dither_value,
	output logic                      cal_start
);
	import sdr_pkg::*;

	// Link domain: only the shifter runs on the serial clock. That clock stops
	// outside frames, so nothing here may depend on a reset
	logic [WORD_W-1:0] shift_r, shift_nxt;

	always_comb begin
		shift_nxt = shift_r;
		if (!link.sload) begin
			shift_nxt = {shift_r[WORD_W-2:0], link.sdata}; // [R13]
		end
	end

	always_ff @(posedge link.sclk) begin
		shift_r <= shift_nxt;
	end

	// System domain: the strobe passes two flops; the word stays quiet while
	// the strobe is high, so it is read only after the synchronised edge
	logic                ld_s1_r, ld_s2_r, ld_s3_r;
	logic                commit;
	logic [ADDR_W-1:0]   sel;
	logic [INT_W-1:0]    int_nxt;
	logic [FIELD_W-1:0]  mod_nxt;
	logic [FIELD_W-1:0]  frac_nxt;
	logic [DITHER_W-1:0] dith_nxt;
	logic                cal_nxt;

	assign commit = ld_s2_r && !ld_s3_r; // [R14]
	assign sel    = shift_r[ADDR_W-1:0];

	always_comb begin
		int_nxt  = int_value;
		mod_nxt  = mod_value;
		frac_nxt = frac_value;
		dith_nxt = dither_value;
		cal_nxt  = 1'b0;
		if (commit) begin
			case (sel)
				SEL_INT: begin
					int_nxt = shift_r[FIELD_LSB+INT_W-1:FIELD_LSB];
					cal_nxt = 1'b1; // [R10]
				end
				SEL_MOD: begin
					mod_nxt = shift_r[FIELD_MSB:FIELD_LSB]; // [R1] [R3] [R15]
					cal_nxt = 1'b1; // [R10]
				end
				SEL_FRAC: begin
					frac_nxt = shift_r[FIELD_MSB:FIELD_LSB]; // [R5] [R7] [R15]
					cal_nxt  = 1'b1; // [R10]
				end
				SEL_DITHER: begin
					dith_nxt = shift_r[DITHER_LSB+DITHER_W-1:DITHER_LSB]; // [R8]
				end
				default: begin
					cal_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			// Strobe idles high, so reset must not leave a false rising edge
			ld_s1_r      <= 1'b1;
			ld_s2_r      <= 1'b1;
			ld_s3_r      <= 1'b1;
			int_value    <= INT_RESET;
			mod_value    <= MOD_RESET;   // [R3]
			frac_value   <= FRAC_RESET;  // [R7]
			dither_value <= DITHER_RESET;
			cal_start    <= 1'b0;
		end else begin
			ld_s1_r      <= link.sload;
			ld_s2_r      <= ld_s1_r;
			ld_s3_r      <= ld_s2_r;
			// Values feed the VCO equation f = pfd x (int + frac/mod) x 2 [R12]
			int_value    <= int_nxt;
			mod_value    <= mod_nxt;
			frac_value   <= frac_nxt;
			dither_value <= dith_nxt;
			cal_start    <= cal_nxt;
		end
	end
endmodule // sdr_device
`default_nettype wire

// File: testbench/sdr_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sdr_properties (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        sclk,
	input wire logic        sload,
	input wire logic [10:0] mod_value,
	input wire logic [10:0] frac_value,
	input wire logic [16:0] dither_value,
	input wire logic        cal_start
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence sclk_tail;
		sclk ##1 !sclk;
	endsequence
	// Dither commits must not kick the calibration
	sequence cal_quiet;
		!cal_start [*3];
	endsequence
	chk_sclk_ratio: assert property ($rose(sclk) |=> sclk_tail)
		else $error("serial clock not a quarter of clock");
	chk_frame_low: assert property ($fell(sload) |-> !sload [*8])
		else $error("load line rose inside a word");
	chk_cal_pulse: assert property (cal_start |=> !cal_start)
		else $error("calibration start longer than one cycle");
	chk_mod_commit: assert property ($changed(mod_value) |-> sload)
		else $error("modulus changed while shifting");
	chk_frac_commit: assert property ($changed(frac_value) |-> sload)
		else $error("fraction changed while shifting");
	chk_dith_commit: assert property ($changed(dither_value) |-> sload)
		else $error("dither changed while shifting");
	chk_mod_cal: assert property ($changed(mod_value) |-> ##[0:4] cal_start)
		else $error("no calibration after modulus write");
	chk_frac_cal: assert property ($changed(frac_value) |-> ##[0:4] cal_start)
		else $error("no calibration after fraction write");
	chk_dith_quiet: assert property ($changed(dither_value) |-> cal_quiet)
		else $error("calibration after dither write");
endmodule // sdr_properties
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import sdr_pkg::*;
	logic        clock, rstn, psel, penable, pwrite, pready, pslverr, cal_start, dv;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [6:0]  int_value;
	logic [10:0] mod_value, frac_value;
	logic [16:0] dither_value;
	int          error_cnt = 0, n_tests = 0, cal_n = 0, c0;
	// Upper junk in words 2 to 4 proves it is ignored; dividers go last
	logic [23:0] w_t [7] = '{24'h000003, 24'h0FFFFB, 24'hFFFFFF, 24'hFFFFF9,
		24'hAABFF2, 24'h000002, 24'h000009};
	logic [10:0] m_t [7] = '{11'h600, 11'h600, 11'h600, 11'h7FF, 11'h7FF, 11'h7FF, 11'h001};
	logic [10:0] f_t [7] = '{11'h300, 11'h300, 11'h300, 11'h300, 11'h7FE, 11'h000, 11'h000};
	logic [16:0] d_t [7] = '{17'h00000, 17'h1FFFF, 17'h1FFFF, 17'h1FFFF, 17'h1FFFF,
		17'h1FFFF, 17'h1FFFF};
	sdr_link_if i_sdr_link_if ();
	sdr_host i_sdr_host (.link(i_sdr_link_if), .clock(clock), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	sdr_device i_sdr_device (.link(i_sdr_link_if), .clock(clock), .rstn(rstn),
		.int_value(int_value), .mod_value(mod_value), .frac_value(frac_value),
		.dither_value(dither_value), .cal_start(cal_start));
	sdr_properties i_sdr_properties (.clock(clock), .rstn(rstn), .sclk(i_sdr_link_if.sclk),
		.sload(i_sdr_link_if.sload), .mod_value(mod_value), .frac_value(frac_value),
		.dither_value(dither_value), .cal_start(cal_start));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) if (cal_start === 1'b1) cal_n++;
	task automatic conclude;
		if (error_cnt == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Idle cycle first so psel is never assigned twice in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic send(input logic [23:0] w);
		apb(1'b1, A_DATA, {8'h00, w}, q);
		apb(1'b1, A_CTRL, 32'h00000001, q);
		do apb(1'b0, A_STAT, 32'h0, q); while (q[STAT_BUSY] !== 1'b0);
		repeat (6) @(posedge clock);
	endtask
	initial begin
		#200000;
		error_cnt++;
		conclude;
	end
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		apb(1'b1, 8'h0C, 32'hFFFFFFFF, q);
		apb(1'b0, 8'h0C, 32'h0, q);
		chk(q, 32'h0);
		chk(mod_value, 11'h600);
		chk(frac_value, 11'h300);
		chk(dither_value, 17'h00001);
		for (int i = 0; i < 7; i++) begin
			c0 = cal_n;
			send(w_t[i]);
			dv = (w_t[i][2:0] == SEL_MOD) || (w_t[i][2:0] == SEL_FRAC);
			chk(mod_value, m_t[i]);
			chk(frac_value, f_t[i]);
			chk(dither_value, d_t[i]);
			chk(cal_n - c0, dv);
			if (w_t[i][2:0] < 3'h4) chk(q[STAT_CAL], dv);
		end
		chk(int_value, INT_RESET);
		conclude;
	end
endmodule // tb
`default_nettype wire
